/* hdl/phy_mgmt_status_mmd_regs.sv */
// Functional notes
// - Config fault bit 15 latches until read
// - Bit 14 shows effective master role: manual setting when enabled, else resolution result
// - Bit 13 shows local receiver OK
// - Bit 12 shows remote receiver OK
// - Bits 11/10 show partner full/half duplex
// - Bits 7:0 count idle errors, clear on read
// - Idle error counter saturates at maximum
// - Control bits 15:14 pick MMD function
// - Control bits 4:0 pick MMD device
// - Function 00 accesses stored MMD address
// - Other functions move data at stored address
// - Function 01 never changes the address
// - Function 10 increments after reads and writes
// - Function 11 increments after writes only
// - Capability bits 15:14 read constant zero
// - Capability bit 13 reads constant one
// - Capability bit 12 reads constant zero
// - Loopback bit 8 enables, resets to zero
// - Manual master/slave setting overrides resolution
`timescale 1ns/10ps
`default_nettype none

module phy_mgmt_status_mmd_regs #(
    parameter int MMD_DEV_IDX_W  = 2,   // Device select bits that index storage
    parameter int MMD_ADDR_IDX_W = 4    // Address bits that index storage
) (
    input  wire logic                       clk,             // Management clock
    input  wire logic                       srst,            // Sync reset, high
    input  wire logic                       mdc,             // Management data clock pin
    input  wire logic                       mdio_in,         // Management data pin in
    output logic                            mdio_out,        // Management data pin out
    output logic                            mdio_oe_n,       // Low while driving pin
    input  wire logic [4:0]                 phy_addr,        // Strapped PHY address
    input  wire mgmt_regs_pkg::line_status_t line_status,    // Live link status
    input  wire logic                       ms_fault_evt,    // Config fault pulse
    input  wire logic                       ms_manual_en,    // Manual master/slave on
    input  wire logic                       ms_manual_value, // Manual master select
    output logic                            local_is_master, // Effective master role
    input  wire logic                       rx_clk,          // Link receive clock
    input  wire logic                       idle_err_evt,    // Idle error, rx_clk pulse
    input  wire mgmt_regs_pkg::link_byte_t  rx_byte,         // Received byte, rx_clk
    input  wire mgmt_regs_pkg::link_byte_t  tx_byte_in,      // Normal transmit byte
    output mgmt_regs_pkg::link_byte_t       tx_byte_out      // Byte to transmitter
);
    import mgmt_regs_pkg::*;

    // Only the low device and address bits index storage; higher ones alias
    localparam int MEM_IDX_W = MMD_DEV_IDX_W + MMD_ADDR_IDX_W;

    typedef enum {ST_PRE, ST_HDR, ST_TA, ST_RD, ST_WR} mdio_state_t;

    // Pin synchronisers; first stages feed only second stages
    logic mdc_s1_q, mdc_s2_q, mdc_s3_q, mdio_s1_q, mdio_s2_q;
    logic [4:0] phy_s1_q, phy_s2_q;
    always_ff @(posedge clk) begin
        mdc_s1_q  <= mdc;
        mdc_s2_q  <= mdc_s1_q;
        mdc_s3_q  <= mdc_s2_q;
        mdio_s1_q <= mdio_in;
        mdio_s2_q <= mdio_s1_q;
        phy_s1_q  <= phy_addr;
        phy_s2_q  <= phy_s1_q;
    end
    logic mdc_rise;
    assign mdc_rise = mdc_s2_q & ~mdc_s3_q;

    // Loopback enable lives in the management domain; the link side sees it late
    logic       rlb_en_q, rlb_en_d;

    // Link side: reset, loopback level and idle error pointer
    logic       rst_l1_q, rst_l2_q, rlb_l1_q, rlb_l2_q;
    logic [2:0] err_gray_q, err_gray_d, err_bin_l_q, err_bin_l_d;
    link_byte_t tx_q, tx_d;

    always_comb begin
        err_bin_l_d = err_bin_l_q;
        if (idle_err_evt) begin
            err_bin_l_d = err_bin_l_q + 3'h1;
        end
        err_gray_d = err_bin_l_d ^ (err_bin_l_d >> 1);
        tx_d = rlb_l2_q ? rx_byte : tx_byte_in;
        if (rst_l2_q) begin
            err_bin_l_d = 3'h0;
            err_gray_d  = 3'h0;
            tx_d        = '0;
        end
    end

    always_ff @(posedge rx_clk) begin
        rst_l1_q    <= srst;
        rst_l2_q    <= rst_l1_q;
        rlb_l1_q    <= rlb_en_q;
        rlb_l2_q    <= rlb_l1_q;
        err_bin_l_q <= err_bin_l_d;
        err_gray_q  <= err_gray_d;
        tx_q        <= tx_d;
    end
    assign tx_byte_out = tx_q;

    // Gray pointer into the management domain
    // One bit moves per step, so a sample taken mid-change is old or new
    logic [2:0] gray_s1_q, gray_s2_q, seen_q, seen_d, ptr_bin, err_delta;
    always_ff @(posedge clk) begin
        gray_s1_q <= err_gray_q;
        gray_s2_q <= gray_s1_q;
    end
    always_comb begin
        ptr_bin[2] = gray_s2_q[2];
        ptr_bin[1] = gray_s2_q[2] ^ gray_s2_q[1];
        ptr_bin[0] = gray_s2_q[2] ^ gray_s2_q[1] ^ gray_s2_q[0];
        err_delta  = ptr_bin - seen_q;
    end

    // Register state
    logic                 fault_q, fault_d;
    logic [7:0]           idle_cnt_q, idle_cnt_d;
    logic [1:0]           mmd_func_q, mmd_func_d;
    logic [4:0]           mmd_dev_q, mmd_dev_d;
    logic [15:0]          mmd_addr_q, mmd_addr_d;
    logic [15:0]          mmd_mem [2**MEM_IDX_W];
    logic                 mem_we;
    logic [MEM_IDX_W-1:0] mem_idx;

    // Serial frame state
    mdio_state_t st_q, st_d;
    logic [5:0]  pre_cnt_q, pre_cnt_d;
    logic [3:0]  bit_cnt_q, bit_cnt_d;
    logic [12:0] hdr_q, hdr_d;
    logic [12:0] hdr_next;
    logic [15:0] sh_q, sh_d;
    logic        is_rd_q, is_rd_d, out_q, out_d, oe_n_q, oe_n_d;
    logic [4:0]  reg_sel;
    logic        hdr_done, frame_ok, rd_evt, wr_evt;
    logic [15:0] rd_data, wr_data;
    logic [8:0]  idle_sum;

    assign mem_idx = {mmd_dev_q[MMD_DEV_IDX_W-1:0], mmd_addr_q[MMD_ADDR_IDX_W-1:0]};

    assign local_is_master = ms_manual_en ? ms_manual_value : line_status.resolved_master;

    // Header word as it stands once the bit now on the pin is shifted in
    assign hdr_next = {hdr_q[11:0], mdio_s2_q};
    assign reg_sel  = hdr_next[4:0];
    // Done at the rise that samples the last register address bit
    assign hdr_done = (st_q == ST_HDR) && mdc_rise && (bit_cnt_q == HDR_BITS_LAST);
    assign frame_ok = hdr_next[12] && (hdr_next[9:5] == phy_s2_q);
    assign rd_evt   = hdr_done && frame_ok && (hdr_next[11:10] == OP_READ);
    // Write lands at the rise that samples the last data bit
    assign wr_evt   = (st_q == ST_WR) && mdc_rise && (bit_cnt_q == DATA_BITS_LAST);
    assign wr_data  = {sh_q[14:0], mdio_s2_q};

    always_comb begin
        rd_data = 16'h0000;
        case (reg_sel)
            REG_MS_STATUS: begin
                rd_data[MS_FAULT_BIT]  = fault_q;
                rd_data[MS_MASTER_BIT] = local_is_master;
                rd_data[MS_LOC_OK_BIT] = line_status.local_rx_ok;
                rd_data[MS_REM_OK_BIT] = line_status.remote_rx_ok;
                rd_data[MS_LP_FD_BIT]  = line_status.lp_1000_fd;
                rd_data[MS_LP_HD_BIT]  = line_status.lp_1000_hd;
                rd_data[7:0]           = idle_cnt_q;
            end
            REG_MMD_CTRL: begin
                rd_data[MMD_FUNC_LSB+:2] = mmd_func_q;
                rd_data[MMD_DEV_LSB+:5]  = mmd_dev_q;
            end
            REG_MMD_ADDR_DATA: rd_data = (mmd_func_q == MMD_FN_ADDR) ? mmd_addr_q
                                                                  : mmd_mem[mem_idx];
            REG_EXT_CAP:    rd_data = EXT_CAP_VALUE;
            REG_RLOOP_CTRL: rd_data[RLOOP_EN_BIT] = rlb_en_q;
            default:        rd_data = 16'h0000;
        endcase
    end

    // Serial frame sequencer
    always_comb begin
        st_d      = st_q;
        pre_cnt_d = pre_cnt_q;
        bit_cnt_d = bit_cnt_q;
        hdr_d     = hdr_q;
        sh_d      = sh_q;
        is_rd_d   = is_rd_q;
        out_d     = out_q;
        oe_n_d    = oe_n_q;
        if (st_q == ST_HDR && mdc_rise) begin
            hdr_d = hdr_next;
        end

        if (mdc_rise) begin
            case (st_q)
                ST_PRE: begin
                    if (mdio_s2_q) begin
                        if (pre_cnt_q != PREAMBLE_ONES) begin
                            pre_cnt_d = pre_cnt_q + 6'h1;
                        end
                    end else begin
                        if (pre_cnt_q == PREAMBLE_ONES) begin
                            st_d      = ST_HDR;
                            bit_cnt_d = 4'h0;
                        end
                        pre_cnt_d = 6'h0;
                    end
                end
                ST_HDR: begin
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    if (hdr_done) begin
                        bit_cnt_d = 4'h0;
                        is_rd_d   = rd_evt;
                        sh_d      = rd_data;
                        // Other opcodes or addresses go back to hunting a preamble
                        st_d      = (frame_ok && (hdr_next[11:10] == OP_READ ||
                                     hdr_next[11:10] == OP_WRITE)) ? ST_TA : ST_PRE;
                    end
                end
                ST_TA: begin
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    if (bit_cnt_q == 4'h0) begin
                        // Turnaround zero for reads only
                        out_d  = 1'b0;
                        oe_n_d = ~is_rd_q;
                    end else begin
                        bit_cnt_d = 4'h0;
                        st_d      = is_rd_q ? ST_RD : ST_WR;
                        if (is_rd_q) begin
                            out_d = sh_q[15];
                            sh_d  = {sh_q[14:0], 1'b0};
                        end
                    end
                end
                ST_RD: begin
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    out_d     = sh_q[15];
                    sh_d      = {sh_q[14:0], 1'b0};
                    if (bit_cnt_q == DATA_BITS_LAST) begin
                        oe_n_d = 1'b1;
                        out_d  = 1'b1;
                        st_d   = ST_PRE;
                    end
                end
                ST_WR: begin
                    bit_cnt_d = bit_cnt_q + 4'h1;
                    sh_d      = wr_data;
                    if (bit_cnt_q == DATA_BITS_LAST) begin
                        st_d = ST_PRE;
                    end
                end
                default: st_d = ST_PRE;
            endcase
        end

        if (srst) begin
            st_d      = ST_PRE;
            pre_cnt_d = 6'h0;
            bit_cnt_d = 4'h0;
            hdr_d     = 13'h0000;
            sh_d      = 16'h0000;
            is_rd_d   = 1'b0;
            out_d     = 1'b1;
            oe_n_d    = 1'b1;
        end
    end

    // Register side effects
    always_comb begin
        fault_d    = fault_q;
        rlb_en_d   = rlb_en_q;
        mmd_func_d = mmd_func_q;
        mmd_dev_d  = mmd_dev_q;
        mmd_addr_d = mmd_addr_q;
        // Errors are taken as a pointer difference, so none are lost across reads
        seen_d     = ptr_bin;
        mem_we     = 1'b0;
        // clear on read, new errors kept
        if (rd_evt && reg_sel == REG_MS_STATUS) begin
            idle_sum = {6'h00, err_delta};
        end else begin
            idle_sum = {1'b0, idle_cnt_q} + {6'h00, err_delta};
        end

        idle_cnt_d = idle_sum[8] ? IDLE_ERR_MAX : idle_sum[7:0];

        if (rd_evt && reg_sel == REG_MS_STATUS) begin
            fault_d = 1'b0;
        end
        if (ms_fault_evt) begin
            fault_d = 1'b1;
        end

        if (rd_evt && reg_sel == REG_MMD_ADDR_DATA && mmd_func_q == MMD_FN_INC_RW) begin
            mmd_addr_d = mmd_addr_q + 16'h0001;
        end

        if (wr_evt) begin
            case (hdr_q[4:0])
                REG_MMD_CTRL: begin
                    mmd_func_d = wr_data[MMD_FUNC_LSB+:2];
                    mmd_dev_d  = wr_data[MMD_DEV_LSB+:5];
                end
                REG_MMD_ADDR_DATA: begin
                    if (mmd_func_q == MMD_FN_ADDR) begin
                        mmd_addr_d = wr_data;
                    end else begin
                        mem_we = 1'b1;
                        if (mmd_func_q != MMD_FN_DATA) begin
                            mmd_addr_d = mmd_addr_q + 16'h0001;
                        end
                    end
                end
                REG_RLOOP_CTRL: rlb_en_d = wr_data[RLOOP_EN_BIT];
                default: ;
            endcase
        end

        if (srst) begin
            fault_d    = 1'b0;
            idle_cnt_d = 8'h00;
            rlb_en_d   = 1'b0;
            mmd_func_d = MMD_FN_ADDR;
            mmd_dev_d  = 5'h00;
            mmd_addr_d = MMD_ADDR_RESET;
        end
    end

    always_ff @(posedge clk) begin
        st_q       <= st_d;
        pre_cnt_q  <= pre_cnt_d;
        bit_cnt_q  <= bit_cnt_d;
        hdr_q      <= hdr_d;
        sh_q       <= sh_d;
        is_rd_q    <= is_rd_d;
        out_q      <= out_d;
        oe_n_q     <= oe_n_d;
        fault_q    <= fault_d;
        idle_cnt_q <= idle_cnt_d;
        seen_q     <= seen_d;
        rlb_en_q   <= rlb_en_d;
        mmd_func_q <= mmd_func_d;
        mmd_dev_q  <= mmd_dev_d;
        mmd_addr_q <= mmd_addr_d;
    end

    // MMD storage has no reset; contents are undefined until written
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mmd_mem[mem_idx] <= wr_data;
        end
    end

    assign mdio_out  = out_q;
    assign mdio_oe_n = oe_n_q;

endmodule : phy_mgmt_status_mmd_regs
`default_nettype wire

/* shared/mgmt_regs_pkg.sv */
package mgmt_regs_pkg;

    // Register indices on the serial management bus
    localparam logic [4:0] REG_MS_STATUS   = 5'h0a;
    localparam logic [4:0] REG_MMD_CTRL    = 5'h0d;
    localparam logic [4:0] REG_MMD_ADDR_DATA = 5'h0e;
    localparam logic [4:0] REG_EXT_CAP     = 5'h0f;
    localparam logic [4:0] REG_RLOOP_CTRL  = 5'h11;

    // Field positions
    localparam int MS_FAULT_BIT   = 15;
    localparam int MS_MASTER_BIT  = 14;
    localparam int MS_LOC_OK_BIT  = 13;
    localparam int MS_REM_OK_BIT  = 12;
    localparam int MS_LP_FD_BIT   = 11;
    localparam int MS_LP_HD_BIT   = 10;
    localparam int MMD_FUNC_LSB   = 14;
    localparam int MMD_DEV_LSB    = 0;
    localparam int RLOOP_EN_BIT   = 8;

    // Reset values and constants
    localparam logic [15:0] EXT_CAP_VALUE   = 16'h2000;
    localparam logic [15:0] MMD_ADDR_RESET  = 16'h0000;
    localparam logic [7:0]  IDLE_ERR_MAX    = 8'hff;
    localparam logic [5:0]  PREAMBLE_ONES   = 6'h20;
    localparam logic [3:0]  HDR_BITS_LAST   = 4'hc;
    localparam logic [3:0]  DATA_BITS_LAST  = 4'hf;

    typedef enum logic [1:0] {
        MMD_FN_ADDR    = 2'b00,
        MMD_FN_DATA    = 2'b01,
        MMD_FN_INC_RW  = 2'b10,
        MMD_FN_INC_WR  = 2'b11
    } mmd_func_t;

    localparam logic [1:0] OP_READ  = 2'b10;
    localparam logic [1:0] OP_WRITE = 2'b01;

    // Live status from the 1000BASE-T resolution and receive logic
    typedef struct packed {
        logic resolved_master;
        logic local_rx_ok;
        logic remote_rx_ok;
        logic lp_1000_fd;
        logic lp_1000_hd;
    } line_status_t;

    // Receive or transmit byte on the link side
    typedef struct packed {
        logic       dv;
        logic       er;
        logic [7:0] data;
    } link_byte_t;

endpackage : mgmt_regs_pkg

/* verification/phy_mgmt_checker_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_checker (
    input wire logic                        clk,             // Mgmt clock
    input wire logic                        srst,            // Sync reset
    input wire logic                        mdc,             // Serial clock
    input wire logic                        mdio_in,         // Pin level
    input wire logic                        mdio_out,        // Pin drive
    input wire logic                        mdio_oe_n,       // Drive enable
    input wire logic [4:0]                  phy_addr,        // Strap
    input wire mgmt_regs_pkg::line_status_t line_status,     // Line state
    input wire logic                        ms_fault_evt,    // Fault pulse
    input wire logic                        ms_manual_en,    // Manual on
    input wire logic                        ms_manual_value, // Manual role
    input wire logic                        local_is_master, // Role out
    input wire logic                        rx_clk,          // Link clock
    input wire logic                        idle_err_evt,    // Idle error
    input wire mgmt_regs_pkg::link_byte_t   rx_byte,         // Rx byte
    input wire mgmt_regs_pkg::link_byte_t   tx_byte_in,      // Tx byte
    input wire mgmt_regs_pkg::link_byte_t   tx_byte_out      // Loop output
);
    logic       mdc_q;
    logic [4:0] rise_cnt_q;
    logic [4:0] rise_cnt_d;

    // Counts clock rises inside one drive window
    always_comb begin
        rise_cnt_d = rise_cnt_q;
        if (srst || mdio_oe_n)
            rise_cnt_d = 5'h00;
        else if (mdc && !mdc_q)
            rise_cnt_d = rise_cnt_q + 5'h01;
    end
    always_ff @(posedge clk) begin
        mdc_q <= mdc;
        rise_cnt_q <= rise_cnt_d;
    end

    sequence s_turn;
        $fell(mdio_oe_n);
    endsequence
    sequence s_in_reset;
        srst ##1 srst;
    endsequence

    a_role_override: assert property (@(posedge clk) disable iff (srst)
        ms_manual_en |-> local_is_master == ms_manual_value)
        else $error("manual role not applied");
    a_role_resolved: assert property (@(posedge clk) disable iff (srst)
        !ms_manual_en |-> local_is_master == line_status.resolved_master)
        else $error("resolved role not shown");
    a_turn_low: assert property (@(posedge clk) disable iff (srst)
        s_turn |-> !mdio_out)
        else $error("turnaround not driven low");
    a_drive_span: assert property (@(posedge clk) disable iff (srst)
        $rose(mdio_oe_n) |-> rise_cnt_q == 5'h11)
        else $error("read drive window wrong length");
    a_bit_hold: assert property (@(posedge clk) disable iff (srst)
        !mdio_oe_n && !$past(mdio_oe_n) && !mdc && !mdc_q |-> $stable(mdio_out))
        else $error("read bit moved in low phase");
    a_reset_idle: assert property (@(posedge clk)
        s_in_reset |-> mdio_oe_n && mdio_out)
        else $error("pin not released in reset");
    a_tx_reset: assert property (@(posedge rx_clk)
        srst [*4] |-> tx_byte_out == '0)
        else $error("transmit byte not cleared in reset");
    a_loop_source: assert property (@(posedge rx_clk) disable iff (srst)
        tx_byte_out == $past(rx_byte) || tx_byte_out == $past(tx_byte_in)
        || tx_byte_out == '0)
        else $error("transmit byte from no source");
endmodule : phy_mgmt_checker

bind phy_mgmt_status_mmd_regs phy_mgmt_checker chk_i (.clk(clk), .srst(srst), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(phy_addr),
    .line_status(line_status), .ms_fault_evt(ms_fault_evt), .ms_manual_en(ms_manual_en),
    .ms_manual_value(ms_manual_value), .local_is_master(local_is_master), .rx_clk(rx_clk),
    .idle_err_evt(idle_err_evt), .rx_byte(rx_byte), .tx_byte_in(tx_byte_in),
    .tx_byte_out(tx_byte_out));
`default_nettype wire

/* verification/mgmt_station_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mgmt_station_model (
    input  wire logic clk,       // Timing reference
    input  wire logic mdio_out,  // Device drive value
    input  wire logic mdio_oe_n, // Device drives when low
    output logic      mdc,       // Serial clock, idle low
    output logic      mdio_in    // Resolved line level
);
    logic drv = 1'b1;
    logic drv_en = 1'b0;
    // Line has a pull-up, so a released line reads high
    assign mdio_in = (drv_en ? drv : 1'b1) & (mdio_oe_n ? 1'b1 : mdio_out);
    initial mdc = 1'b0;

    // Change in the low phase, sample just before the rise
    task automatic bit_cyc(input logic b, input logic en, output logic s);
        @(negedge clk);
        mdc = 1'b0;
        drv = b;
        drv_en = en;
        repeat (8) @(negedge clk);
        s = mdio_in;
        mdc = 1'b1;
        repeat (8) @(negedge clk);
    endtask : bit_cyc

    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic        s;
        logic        w;
        logic [13:0] hdr;
        w = (op == mgmt_regs_pkg::OP_WRITE);
        hdr = {2'b01, op, pa, ra};
        for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
        for (int i = 13; i >= 0; i--) bit_cyc(hdr[i], 1'b1, s);
        bit_cyc(1'b1, w, s);
        bit_cyc(1'b0, w, s);
        for (int i = 15; i >= 0; i--) bit_cyc(wd[i], w, rd[i]);
        @(negedge clk);
        mdc = 1'b0;
        drv_en = 1'b0;
        repeat (4) @(negedge clk);
    endtask : frame
endmodule : mgmt_station_model
`default_nettype wire

/* verification/phy_mgmt_status_mmd_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_status_mmd_regs_bench;
    import mgmt_regs_pkg::*;
    localparam logic [4:0] PHY = 5'h03;
    logic         clk = 1'b0;
    logic         rx_clk = 1'b0;
    logic         srst = 1'b1;
    logic         mdc, mdio_in, mdio_out, mdio_oe_n, lim;
    logic         flt = 1'b0;
    logic         men = 1'b0;
    logic         mval = 1'b0;
    logic         ierr = 1'b0;
    logic         lb = 1'b0;
    logic         lchk = 1'b0;
    line_status_t ls = '0;
    link_byte_t   rxb = '0;
    link_byte_t   txi = '0;
    link_byte_t   txo, want;
    int           mismatches = 0;
    int           total_checks = 0;

    always #25 clk = ~clk;
    initial begin
        #7;
        forever #15 rx_clk = ~rx_clk;
    end

    phy_mgmt_status_mmd_regs dut (.clk(clk), .srst(srst), .mdc(mdc), .mdio_in(mdio_in),
        .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .phy_addr(PHY), .line_status(ls),
        .ms_fault_evt(flt), .ms_manual_en(men), .ms_manual_value(mval),
        .local_is_master(lim), .rx_clk(rx_clk), .idle_err_evt(ierr), .rx_byte(rxb),
        .tx_byte_in(txi), .tx_byte_out(txo));
    mgmt_station_model sm (.clk(clk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
        .mdc(mdc), .mdio_in(mdio_in));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    task automatic wr(input logic [4:0] ra, input logic [15:0] d, input logic [4:0] pa = PHY);
        logic [15:0] x;
        sm.frame(OP_WRITE, pa, ra, d, x);
    endtask : wr

    task automatic rchk(input logic [4:0] ra, input logic [15:0] e);
        logic [15:0] d;
        sm.frame(OP_READ, PHY, ra, 16'h0000, d);
        chk(d, e);
    endtask : rchk

    task automatic pulse_idle(input int n);
        repeat (n) begin
            @(negedge rx_clk) ierr <= 1'b1;
            @(negedge rx_clk) ierr <= 1'b0;
        end
    endtask : pulse_idle

    function automatic logic [15:0] st_exp(input logic f, input logic [7:0] n);
        return {f, men ? mval : ls.resolved_master, ls.local_rx_ok, ls.remote_rx_ok,
                ls.lp_1000_fd, ls.lp_1000_hd, 2'b00, n};
    endfunction : st_exp

    // Link traffic runs all the time; compared only once the loop state has settled
    always @(negedge rx_clk) begin
        if (lchk)
            chk(16'(txo), 16'(want));
        rxb <= link_byte_t'(10'($urandom));
        txi <= link_byte_t'(10'($urandom));
    end
    always @(posedge rx_clk) want <= lb ? rxb : txi;

    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        logic [15:0] a;
        logic [15:0] d;
        logic [4:0]  dv;
        int          n;
        void'($urandom(42682));
        repeat (16) @(negedge clk);
        chk(16'({mdio_oe_n, mdio_out, txo}), 16'h0c00);
        srst = 1'b0;
        rchk(REG_RLOOP_CTRL, 16'h0000);
        wr(REG_EXT_CAP, 16'hffff);
        rchk(REG_EXT_CAP, 16'h2000);
        rchk(5'h1f, 16'h0000);
        repeat (4) begin
            ls = line_status_t'(5'($urandom));
            {men, mval} = 2'($urandom);
            @(negedge clk);
            chk(16'(lim), 16'(men ? mval : ls.resolved_master));
            rchk(REG_MS_STATUS, st_exp(1'b0, 8'h00));
        end
        @(negedge clk) flt = 1'b1;
        @(negedge clk) flt = 1'b0;
        rchk(REG_MS_STATUS, st_exp(1'b1, 8'h00));
        rchk(REG_MS_STATUS, st_exp(1'b0, 8'h00));
        n = $urandom_range(40, 1);
        pulse_idle(n);
        repeat (8) @(negedge clk);
        rchk(REG_MS_STATUS, st_exp(1'b0, 8'(n)));
        rchk(REG_MS_STATUS, st_exp(1'b0, 8'h00));
        // More errors than the counter holds, to reach its ceiling
        pulse_idle(300);
        repeat (8) @(negedge clk);
        rchk(REG_MS_STATUS, st_exp(1'b0, 8'hff));
        dv = 5'($urandom_range(3, 0));
        a = 16'($urandom_range(12, 0));
        d = 16'($urandom);
        wr(REG_MMD_CTRL, {2'b00, 9'h1ff, dv});
        rchk(REG_MMD_CTRL, {2'b00, 9'h000, dv});
        wr(REG_MMD_ADDR_DATA, a);
        rchk(REG_MMD_ADDR_DATA, a);
        wr(REG_MMD_CTRL, {2'b01, 9'h000, dv});
        wr(REG_MMD_ADDR_DATA, d);
        rchk(REG_MMD_ADDR_DATA, d);
        rchk(REG_MMD_ADDR_DATA, d);
        wr(REG_MMD_CTRL, {2'b10, 9'h000, dv});
        rchk(REG_MMD_ADDR_DATA, d);
        wr(REG_MMD_ADDR_DATA, ~d);
        wr(REG_MMD_CTRL, {2'b00, 9'h000, dv});
        rchk(REG_MMD_ADDR_DATA, a + 16'h0002);
        wr(REG_MMD_ADDR_DATA, a + 16'h0001);
        wr(REG_MMD_CTRL, {2'b11, 9'h000, dv});
        rchk(REG_MMD_ADDR_DATA, ~d);
        rchk(REG_MMD_ADDR_DATA, ~d);
        wr(REG_MMD_ADDR_DATA, d);
        wr(REG_MMD_CTRL, {2'b00, 9'h000, dv});
        rchk(REG_MMD_ADDR_DATA, a + 16'h0002);
        for (int i = 1; i >= 0; i--) begin
            wr(REG_RLOOP_CTRL, i ? 16'hffff : 16'h0000);
            rchk(REG_RLOOP_CTRL, i ? 16'h0100 : 16'h0000);
            lb = 1'(i);
            repeat (4) @(negedge clk);
            lchk = 1'b1;
            repeat (40) @(negedge clk);
            lchk = 1'b0;
        end
        // A frame for another address must leave the register alone
        wr(REG_RLOOP_CTRL, 16'h0100, PHY ^ 5'h01);
        rchk(REG_RLOOP_CTRL, 16'h0000);
        give_verdict();
    end
endmodule : phy_mgmt_status_mmd_regs_bench
`default_nettype wire
